// ---- verilog/interlock_defines.vh ----
`ifndef INTERLOCK_DEFINES_VH
`define INTERLOCK_DEFINES_VH
// Clock and timing
`define CLK_HZ            20000000
`define FB_WAIT_MS        300
`define FB_WAIT_CYC       ((`CLK_HZ / 1000) * `FB_WAIT_MS)
`define PHASE_MS          500
`define PHASE_CYC         ((`CLK_HZ / 1000) * `PHASE_MS)
`define SEG_STEP_MS       100
`define SEG_STEP_CYC      ((`CLK_HZ / 1000) * `SEG_STEP_MS)
`define ALIGN_HOLD_S      120
`define ALIGN_HOLD_CYC    (`CLK_HZ * `ALIGN_HOLD_S)
// AXI4-Lite register byte addresses
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_IRQ_STAT      8'h08
`define REG_IRQ_CLR       8'h0C
`define REG_IRQ_EN        8'h10
`define REG_CFG_KEEP      8'h14
// Control register fields
`define CTRL_RESET_FN     0
`define CTRL_EDM_MODE     1
`define CTRL_LARGE_RANGE  2
`define CTRL_CODE_LO      3
`define CTRL_CODE_HI      4
`define CTRL_REDUCED      5
`define CTRL_FACTORY      6
`define CTRL_RESET_VAL    32'h00000000
// Interrupt event bits
`define EV_FB_TIMEOUT     0
`define EV_CONTACTOR_BAD  1
`define EV_WIRING_ERR     2
`define EV_ALIGN_DONE     3
`define EV_TEST_REQ       4
`define EV_WIDTH          5
// Display codes (segment patterns, gfedcba)
`define SEG_BLANK         7'h00
`define SEG_RANGE         7'h76
`define SEG_HOST          7'h74
`define SEG_GUEST1        7'h30
`define SEG_GUEST2        7'h5B
`define SEG_CODE0         7'h3F
`define SEG_CODE1         7'h06
`define SEG_CODE2         7'h5B
`define SEG_MARKER        7'h40
`define SEG_ERROR         7'h79
`define SEG_ALIGN0        7'h3F
`define SEG_ALIGN1        7'h06
`define SEG_ALIGN2        7'h5B
`define AXI_OKAY          2'b00
`define AXI_SLVERR        2'b10
`endif

// ---- verilog/sync2.v ----
`timescale 1ns/1ns
// Two-stage synchroniser for a bundle of pin levels
module sync2 #(
  parameter W = 4
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         ce,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_q;

  // First stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ---- verilog/restart_interlock_feedback_monitor.v ----
// Summary of operation
// - After a reset press, both switching outputs drop again unless feedback responds within 300 ms.
// - With feedback monitoring on, after a beam interruption feedback must read high (both break contacts closed) or restart is blocked.
// - The feedback monitoring setting survives power cycles and is cleared only by the configuration reset.
// - Feedback contacts wired while monitoring mode is off raise an error indication.
// - With restart interlock on, outputs stay off until the reset/restart button is operated.
// - The test input low means an external test request, high means none.
// - A fresh unit starts with the reset function off until configuration enables it.
// - Power-up begins with a display test lighting each segment in turn.
// - Only a receiver set for the large range shows a range indication for about 0.5 s.
// - Power-up shows the cascade role (host, guest 1, guest 2) for about 0.5 s.
// - Power-up shows the beam coding (off, code 1, code 2) for about 0.5 s.
// - Once running the indicator is blank, or a marker when reduced resolution or blanking is set.
// - Only a receiver shows alignment quality, and only while alignment is not yet true.
// - Optimum alignment held over two minutes ends alignment mode until the next power cycle.
`timescale 1ns/1ns
`include "interlock_defines.vh"
module restart_interlock_feedback_monitor #(
  parameter PHASE_CYC    = `PHASE_CYC,
  parameter SEG_STEP_CYC = `SEG_STEP_CYC,
  parameter FB_WAIT_CYC  = `FB_WAIT_CYC,
  parameter ALIGN_CYC    = `ALIGN_HOLD_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        is_receiver,
  input  wire        beam_clear,
  input  wire [1:0]  align_quality,
  input  wire [1:0]  cascade_role,
  input  wire        contactor_feedback_monitor,
  input  wire        restart_button,
  input  wire        test_input,
  output reg         safety_switch_out_a,
  output reg         safety_switch_out_b,
  output reg         ext_test_req,
  output reg  [6:0]  segments,
  output reg         irq
);
  // Power-up phases
  localparam PH_SEGTEST = 3'd0;
  localparam PH_RANGE   = 3'd1;
  localparam PH_ROLE    = 3'd2;
  localparam PH_CODE    = 3'd3;
  localparam PH_RUN     = 3'd4;
  // Output interlock states
  localparam OS_LOCKED  = 2'd0;
  localparam OS_WAITFB  = 2'd1;
  localparam OS_ON      = 2'd2;

  // Sync order: feedback, button, test, beam
  wire [3:0] pins_s;
  sync2 #(.W(4)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       ({beam_clear, ~test_input, restart_button, contactor_feedback_monitor}),
    .q       (pins_s)
  );
  wire fb_s   = pins_s[0];
  wire btn_s  = pins_s[1];
  // Stored inverted so reset leaves the idle (high) level, no false request
  wire test_s = ~pins_s[2];
  wire beam_s = pins_s[3];

  reg [31:0] ctrl_q;
  reg        keep_edm_q;
  reg [`EV_WIDTH-1:0] irq_stat_q;
  reg [`EV_WIDTH-1:0] irq_en_q;
  reg [2:0]  phase_q;
  reg [31:0] tmr_q;
  reg [2:0]  seg_idx_q;
  reg [1:0]  os_q;
  reg [31:0] fb_tmr_q;
  reg        btn_prev_q;
  reg        beam_prev_q;
  reg        fault_q;
  reg        align_mode_q;
  reg [31:0] align_tmr_q;
  reg        test_prev_q;
  reg        aw_hold_q;
  reg        w_hold_q;
  reg [7:0]  aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;

  // Merge write data into a word under byte strobes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (st[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  wire edm_on     = ctrl_q[`CTRL_EDM_MODE] | keep_edm_q;
  wire reset_fn   = ctrl_q[`CTRL_RESET_FN];
  wire btn_rise   = btn_s & ~btn_prev_q;
  wire beam_break = beam_prev_q & ~beam_s;
  wire fb_expired = (fb_tmr_q >= FB_WAIT_CYC - 1);
  wire wiring_err = ~edm_on & fb_s;
  wire [`EV_WIDTH-1:0] ev;
  assign ev[`EV_FB_TIMEOUT]    = (os_q == OS_WAITFB) & fb_expired & fb_s;
  assign ev[`EV_CONTACTOR_BAD] = edm_on & beam_break;
  assign ev[`EV_WIRING_ERR]    = wiring_err & (phase_q == PH_RUN);
  assign ev[`EV_ALIGN_DONE]    = align_mode_q & (align_tmr_q >= ALIGN_CYC - 1);
  assign ev[`EV_TEST_REQ]      = ~test_s & test_prev_q;
  // Restart attempt in run phase with the light path clear
  wire restart_try = (phase_q == PH_RUN) & beam_s & (btn_rise | ~reset_fn);

  // AXI write channel; address and data may come in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_OKAY;
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
    end else if (ce) begin
      s_axi_awready <= ~aw_hold_q & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_hold_q & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_hold_q & w_hold_q & ~s_axi_bvalid) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_q)
          `REG_CTRL, `REG_IRQ_CLR, `REG_IRQ_EN, `REG_CFG_KEEP: s_axi_bresp <= `AXI_OKAY;
          `REG_STATUS, `REG_IRQ_STAT:                           s_axi_bresp <= `AXI_OKAY;
          default:                                              s_axi_bresp <= `AXI_SLVERR;
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  wire wr_commit = aw_hold_q & w_hold_q & ~s_axi_bvalid;

  // Register writes; events win over same-cycle clears
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= `CTRL_RESET_VAL;
      irq_en_q   <= {`EV_WIDTH{1'b0}};
      irq_stat_q <= {`EV_WIDTH{1'b0}};
    end else if (ce) begin
      if (wr_commit & (aw_addr_q == `REG_CTRL))
        ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) & 32'h0000003F;
      if (wr_commit & (aw_addr_q == `REG_IRQ_EN))
        irq_en_q <= w_data_q[`EV_WIDTH-1:0];
      if (wr_commit & (aw_addr_q == `REG_IRQ_CLR))
        irq_stat_q <= (irq_stat_q & ~w_data_q[`EV_WIDTH-1:0]) | ev;
      else
        irq_stat_q <= irq_stat_q | ev;
    end
  end

  // retained monitoring setting; not cleared by aresetn
  always @(posedge aclk) begin
    if (ce) begin
      if (wr_commit & (aw_addr_q == `REG_CTRL) & w_strb_q[0] & w_data_q[`CTRL_FACTORY])
        keep_edm_q <= 1'b0;
      else if (wr_commit & (aw_addr_q == `REG_CTRL) & w_strb_q[0] & w_data_q[`CTRL_EDM_MODE])
        keep_edm_q <= 1'b1;
      else if (keep_edm_q !== 1'b1)
        keep_edm_q <= 1'b0;
    end
  end

  // AXI read channel, one cycle after address taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `AXI_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `AXI_OKAY;
        case (s_axi_araddr)
          `REG_CTRL:     s_axi_rdata <= ctrl_q;
          `REG_STATUS:   s_axi_rdata <= {19'h00000, phase_q, os_q, align_mode_q, wiring_err,
                                         fault_q, test_s, btn_s, fb_s, safety_switch_out_a};
          `REG_IRQ_STAT: s_axi_rdata <= {27'h0000000, irq_stat_q};
          `REG_IRQ_EN:   s_axi_rdata <= {27'h0000000, irq_en_q};
          `REG_CFG_KEEP: s_axi_rdata <= {31'h00000000, keep_edm_q};
          `REG_IRQ_CLR:  s_axi_rdata <= 32'h00000000;
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      phase_q   <= PH_SEGTEST;
      tmr_q     <= 32'h00000000;
      seg_idx_q <= 3'd0;
    end else if (ce) begin
      tmr_q <= tmr_q + 32'h00000001;
      case (phase_q)
        PH_SEGTEST: begin
          if (tmr_q >= SEG_STEP_CYC - 1) begin
            tmr_q     <= 32'h00000000;
            seg_idx_q <= seg_idx_q + 3'd1;
            if (seg_idx_q == 3'd6)
              phase_q <= (is_receiver & ctrl_q[`CTRL_LARGE_RANGE]) ? PH_RANGE : PH_ROLE;
          end
        end
        PH_RANGE, PH_ROLE, PH_CODE: begin
          if (tmr_q >= PHASE_CYC - 1) begin
            tmr_q   <= 32'h00000000;
            phase_q <= phase_q + 3'd1;
          end
        end
        PH_RUN:  tmr_q <= 32'h00000000;
        default: phase_q <= PH_SEGTEST;
      endcase
    end
  end

  // Output interlock; outputs only ever enabled in run phase
  always @(posedge aclk) begin
    if (!aresetn) begin
      os_q        <= OS_LOCKED;
      fb_tmr_q    <= 32'h00000000;
      btn_prev_q  <= 1'b0;
      beam_prev_q <= 1'b0;
      test_prev_q <= 1'b1;
      fault_q     <= 1'b0;
    end else if (ce) begin
      btn_prev_q  <= btn_s;
      beam_prev_q <= beam_s;
      test_prev_q <= test_s;
      // contacts checked at restart, after they had time to drop
      if ((os_q == OS_LOCKED) & edm_on & restart_try & ~fb_s)
        fault_q <= 1'b1;
      else if (btn_rise & fb_s)
        fault_q <= 1'b0;
      case (os_q)
        OS_LOCKED: begin
          fb_tmr_q <= 32'h00000000;
          if (restart_try & ~fault_q & ~wiring_err & (~edm_on | fb_s))
            os_q <= edm_on ? OS_WAITFB : OS_ON;
        end
        OS_WAITFB: begin
          fb_tmr_q <= fb_tmr_q + 32'h00000001;
          if (~beam_s)
            os_q <= OS_LOCKED;
          else if (~fb_s)
            os_q <= OS_ON;
          else if (fb_expired)
            os_q <= OS_LOCKED;
        end
        OS_ON: begin
          if (~beam_s | wiring_err)
            os_q <= OS_LOCKED;
        end
        default: os_q <= OS_LOCKED;
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      align_mode_q <= 1'b1;
      align_tmr_q  <= 32'h00000000;
    end else if (ce) begin
      if (~align_mode_q | align_quality != 2'd3 | phase_q != PH_RUN)
        align_tmr_q <= 32'h00000000;
      else if (ev[`EV_ALIGN_DONE])
        align_mode_q <= 1'b0;
      else
        align_tmr_q <= align_tmr_q + 32'h00000001;
    end
  end

  // Indicator and registered outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      segments            <= `SEG_BLANK;
      safety_switch_out_a <= 1'b0;
      safety_switch_out_b <= 1'b0;
      ext_test_req        <= 1'b0;
      irq                 <= 1'b0;
    end else if (ce) begin
      safety_switch_out_a <= (os_q != OS_LOCKED);
      safety_switch_out_b <= (os_q != OS_LOCKED);
      // low test input is a request
      ext_test_req        <= ~test_s;
      irq                 <= |(irq_stat_q & irq_en_q);
      case (phase_q)
        PH_SEGTEST: segments <= 7'h01 << seg_idx_q;
        PH_RANGE:   segments <= `SEG_RANGE;
        PH_ROLE:    segments <= (cascade_role == 2'd0) ? `SEG_HOST :
                                (cascade_role == 2'd1) ? `SEG_GUEST1 : `SEG_GUEST2;
        PH_CODE:    segments <= (ctrl_q[`CTRL_CODE_HI:`CTRL_CODE_LO] == 2'd0) ? `SEG_CODE0 :
                                (ctrl_q[`CTRL_CODE_HI:`CTRL_CODE_LO] == 2'd1) ? `SEG_CODE1 : `SEG_CODE2;
        default: begin
          if (wiring_err | fault_q)
            segments <= `SEG_ERROR;
          else if (is_receiver & align_mode_q & align_quality != 2'd3)
            segments <= (align_quality == 2'd0) ? `SEG_ALIGN0 :
                        (align_quality == 2'd1) ? `SEG_ALIGN1 : `SEG_ALIGN2;
          else
            segments <= ctrl_q[`CTRL_REDUCED] ? `SEG_MARKER : `SEG_BLANK;
        end
      endcase
    end
  end
endmodule

// ---- bench/contactor_model.sv ----
`timescale 1ns/1ns
// Machine contactors whose break contacts feed back to the monitor pin
module contactor_model #(
  parameter DROP_CYC = 3
) (
  input  wire logic aclk,
  input  wire logic coil_a,
  input  wire logic coil_b,
  input  wire logic wired,
  input  wire logic welded,
  input  wire logic no_pickup,
  output logic      feedback
);
  logic [3:0] move_q = 4'h0;
  // Armature travel takes a few cycles, so feedback never answers at once
  always @(posedge aclk) begin
    if (coil_a && coil_b && !no_pickup) begin
      if (move_q < DROP_CYC) move_q <= move_q + 4'h1;
    end else begin
      move_q <= 4'h0;
    end
  end
  // unwired pin held at 0 V
  assign feedback = wired && !welded && (move_q < DROP_CYC);
endmodule

// ---- bench/interlock_monitor.sv ----
`timescale 1ns/1ns
// Port-level checks beside the interlock block
module interlock_monitor #(
  parameter FB_WAIT_CYC = 30
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       beam_clear,
  input wire logic       contactor_feedback_monitor,
  input wire logic       test_input,
  input wire logic       safety_switch_out_a,
  input wire logic       safety_switch_out_b,
  input wire logic       ext_test_req,
  input wire logic [6:0] segments
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [15:0] wait_q;
  // Cycles on without contactor response; margin covers pin sync
  always @(posedge aclk) begin
    if (!aresetn || !(safety_switch_out_a && contactor_feedback_monitor)) begin
      wait_q <= 16'h0000;
    end else begin
      wait_q <= wait_q + 16'h0001;
    end
  end
  property p_fb_wait; wait_q <= FB_WAIT_CYC + 6; endproperty
  a_fb_wait: assert property (p_fb_wait) else $error("outputs held without feedback");
  property p_pair; safety_switch_out_a == safety_switch_out_b; endproperty
  a_pair: assert property (p_pair) else $error("switch outputs differ");
  property p_beam_drop; (!beam_clear) [*6] |-> !safety_switch_out_a; endproperty
  a_beam_drop: assert property (p_beam_drop) else $error("outputs on with beam broken");
  property p_test_on; (!test_input) [*5] |-> ext_test_req; endproperty
  a_test_on: assert property (p_test_on) else $error("test request missing");
  property p_test_off; test_input [*5] |-> !ext_test_req; endproperty
  a_test_off: assert property (p_test_off) else $error("test request spurious");
  property p_pwr_quiet; $rose(aresetn) |-> (!safety_switch_out_a) [*8]; endproperty
  a_pwr_quiet: assert property (p_pwr_quiet) else $error("outputs on during power-up");
  property p_pwr_seg; $rose(aresetn) |-> ##[1:4] $onehot(segments); endproperty
  a_pwr_seg: assert property (p_pwr_seg) else $error("display test not first");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_rhold: assert property (p_rhold) else $error("read response dropped early");
  // Main scenarios reached
  c_on: cover property ($rose(safety_switch_out_a));
  c_off: cover property ($fell(safety_switch_out_a));
  c_test: cover property ($rose(ext_test_req));
endmodule
bind restart_interlock_feedback_monitor interlock_monitor #(.FB_WAIT_CYC(FB_WAIT_CYC)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .beam_clear(beam_clear),
  .contactor_feedback_monitor(contactor_feedback_monitor), .test_input(test_input),
  .safety_switch_out_a(safety_switch_out_a), .safety_switch_out_b(safety_switch_out_b),
  .ext_test_req(ext_test_req), .segments(segments));

// ---- bench/tb_top.sv ----
`timescale 1ns/1ns
`include "interlock_defines.vh"
// Bench for the restart interlock and feedback monitor
module tb_top;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        ce = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'h0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'h0;
  logic        is_receiver = 1'h1;
  logic        beam_clear = 1'h1;
  logic [1:0]  align_quality = 2'h2;
  logic [1:0]  cascade_role = 2'h1;
  logic        contactor_feedback_monitor;
  logic        restart_button = 1'h0;
  logic        test_input = 1'h1;
  logic        safety_switch_out_a;
  logic        safety_switch_out_b;
  logic        ext_test_req;
  logic [6:0]  segments;
  logic        irq;
  logic        wired = 1'h0;
  logic        welded = 1'h0;
  logic        no_pickup = 1'h0;
  logic [6:0]  last_q = 7'h00;
  logic [6:0]  seq[$];
  int          failures = 0;
  int          cmp_count = 0;
  int          cyc_q = 0;

  // Short counts keep the power-up phases within a few hundred cycles
  restart_interlock_feedback_monitor #(.PHASE_CYC(20), .SEG_STEP_CYC(4), .FB_WAIT_CYC(30), .ALIGN_CYC(50)) dut_u (.*);
  contactor_model cont_u (.aclk(aclk), .coil_a(safety_switch_out_a), .coil_b(safety_switch_out_b),
    .wired(wired), .welded(welded), .no_pickup(no_pickup), .feedback(contactor_feedback_monitor));

  always #25 aclk = ~aclk;

  // Records every new indicator pattern once out of reset
  always @(posedge aclk) begin
    if (aresetn && segments !== last_q) seq.push_back(segments);
    last_q <= segments;
  end

  // Hang guard, well above the roughly 600 cycles the run needs
  always @(posedge aclk) begin
    cyc_q <= cyc_q + 1;
    if (cyc_q == 20000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data offered together, each released once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ga;
    logic gw;
    ga = 1'h0;
    gw = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      ga = ga | s_axi_awready;
      gw = gw | s_axi_wready;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    while (!s_axi_rvalid) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic rbit(input logic [7:0] a, input int b, input logic e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk({31'h0, d[b]}, {31'h0, e});
  endtask

  task automatic press;
    restart_button <= 1'h1;
    cyc(4);
    restart_button <= 1'h0;
    cyc(4);
  endtask

  task automatic t_powerup;
    logic [6:0]  exp[$];
    logic [31:0] d;
    logic [1:0]  r;
    cyc(20);
    aresetn <= 1'h1;
    @(posedge aclk);
    axr(`REG_CTRL, d, r);
    chk(d, `CTRL_RESET_VAL);
    axr(8'h40, d, r);
    chk(r, `AXI_SLVERR);
    axw(`REG_CTRL, 32'h0000000C);
    cyc(200);
    exp = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, `SEG_RANGE, `SEG_GUEST1, `SEG_CODE1, `SEG_ALIGN2};
    chk(seq.size(), 11);
    foreach (exp[i]) chk(seq[i], exp[i]);
  endtask

  task automatic t_align;
    align_quality <= 2'h3;
    cyc(8);
    chk(segments, `SEG_BLANK);
    cyc(60);
    rbit(`REG_IRQ_STAT, `EV_ALIGN_DONE, 1'h1);
    align_quality <= 2'h1;
    cyc(8);
    chk(segments, `SEG_BLANK);
    align_quality <= 2'h3;
    axw(`REG_CTRL, 32'h0000002C);
    cyc(8);
    chk(segments, `SEG_MARKER);
  endtask

  // Beam break then clear with the delivered automatic restart
  task automatic t_auto;
    beam_clear <= 1'h0;
    cyc(8);
    chk(safety_switch_out_a, 1'h0);
    beam_clear <= 1'h1;
    cyc(10);
    chk(safety_switch_out_a, 1'h1);
  endtask

  task automatic t_interlock;
    axw(`REG_CTRL, 32'h0000000B);
    wired <= 1'h1;
    beam_clear <= 1'h0;
    cyc(8);
    beam_clear <= 1'h1;
    cyc(20);
    chk(safety_switch_out_a, 1'h0);
    press();
    chk(safety_switch_out_a, 1'h1);
    cyc(40);
    chk(safety_switch_out_b, 1'h1);
  endtask

  // Welded contact blocks restart; a dead coil trips the timeout
  task automatic t_faults;
    axw(`REG_IRQ_CLR, 32'h0000001F);
    axw(`REG_IRQ_EN, 32'h00000001);
    welded <= 1'h1;
    beam_clear <= 1'h0;
    cyc(8);
    beam_clear <= 1'h1;
    rbit(`REG_IRQ_STAT, `EV_CONTACTOR_BAD, 1'h1);
    press();
    chk(safety_switch_out_a, 1'h0);
    welded <= 1'h0;
    no_pickup <= 1'h1;
    press();
    press();
    cyc(40);
    chk(safety_switch_out_a, 1'h0);
    chk(irq, 1'h1);
    rbit(`REG_IRQ_STAT, `EV_FB_TIMEOUT, 1'h1);
    axw(`REG_IRQ_EN, 32'h00000000);
    cyc(2);
    chk(irq, 1'h0);
    axw(`REG_IRQ_CLR, 32'h00000001);
    rbit(`REG_IRQ_STAT, `EV_FB_TIMEOUT, 1'h0);
    no_pickup <= 1'h0;
  endtask

  task automatic t_misc;
    logic [31:0] d;
    logic [1:0]  r;
    test_input <= 1'h0;
    cyc(6);
    chk(ext_test_req, 1'h1);
    test_input <= 1'h1;
    cyc(6);
    chk(ext_test_req, 1'h0);
    rbit(`REG_IRQ_STAT, `EV_TEST_REQ, 1'h1);
    beam_clear <= 1'h0;
    axw(`REG_CTRL, 32'h00000040);
    cyc(6);
    rbit(`REG_IRQ_STAT, `EV_WIRING_ERR, 1'h1);
    beam_clear <= 1'h1;
    axw(`REG_CTRL, 32'h00000002);
    aresetn <= 1'h0;
    cyc(20);
    aresetn <= 1'h1;
    cyc(2);
    axr(`REG_CFG_KEEP, d, r);
    chk(d != 32'h00000000, 1'h1);
    axw(`REG_CTRL, 32'h00000040);
    cyc(2);
    axr(`REG_CFG_KEEP, d, r);
    chk(d, 32'h00000000);
  endtask

  task automatic wrap_up;
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    t_powerup();
    t_align();
    t_auto();
    t_interlock();
    t_faults();
    t_misc();
    wrap_up();
  end
endmodule
